/* verilog/usc_top.sv */
// Serial port control, configuration, baud prescaler and frame engines
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
module usc_top
	import usc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic global_int_enable_i,
	input wire logic tx_done_irq_taken_i,
	output logic rx_done_irq_o,
	output logic tx_done_irq_o,
	output logic tx_empty_irq_o,
	input wire logic rxd_i,
	output logic rxd_claim_o,
	output logic txd_o,
	output logic txd_oe_o,
	input wire logic sync_serial_clock_i
);
	//-----------------------------------------------------------------
	// Bus slave
	//-----------------------------------------------------------------
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic req, wr, rd;
	usc_ctrl_b_s ctrl_b_ff;
	usc_ctrl_c_s ctrl_c_ff;
	logic [11:0] baud_ff;
	logic double_speed_ff, mpcm_ff;
	logic [8:0] tx_buf_ff;
	logic tx_buf_full_ff, tx_done_ff, tx_hold_ff;
	logic [8:0] rx_buf_ff;
	logic rx_valid_ff, fe_ff, dor_ff, upe_ff;
	logic [7:0] ctrl_a_rd;

	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign ctrl_a_rd = {rx_valid_ff, tx_done_ff, !tx_buf_full_ff, fe_ff,
		dor_ff, upe_ff, double_speed_ff, mpcm_ff};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	// Unmapped offsets read zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_ff <= 32'h0;
		end else if (rd) begin
			unique case (wb_adr_i)
				USC_OFS_DATA: rdat_ff <= {24'h0, rx_buf_ff[7:0]};
				USC_OFS_CTRL_A: rdat_ff <= {24'h0, ctrl_a_rd};
				USC_OFS_CTRL_B: rdat_ff <= {24'h0, ctrl_b_ff[7:2],
					rx_buf_ff[8], ctrl_b_ff[0]};
				USC_OFS_CTRL_C: rdat_ff <= {24'h0, ctrl_c_ff};
				USC_OFS_BAUD_LO: rdat_ff <= {24'h0, baud_ff[7:0]};
				USC_OFS_BAUD_HI: rdat_ff <= {28'h0, baud_ff[11:8]};
				default: rdat_ff <= 32'h0;
			endcase
		end
	end

	//-----------------------------------------------------------------
	// Control registers
	//-----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_b_ff <= USC_RST_CTRL_B;
		end else if (wr && wb_adr_i == USC_OFS_CTRL_B) begin
			ctrl_b_ff <= {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_c_ff <= USC_RST_CTRL_C;
		end else if (wr && wb_adr_i == USC_OFS_CTRL_C) begin
			ctrl_c_ff <= {1'b0, wb_dat_i[6:0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			double_speed_ff <= 1'b0;
			mpcm_ff <= 1'b0;
		end else if (wr && wb_adr_i == USC_OFS_CTRL_A) begin
			double_speed_ff <= wb_dat_i[1];
			mpcm_ff <= wb_dat_i[0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_ff <= USC_RST_BAUD;
		end else if (wr && wb_adr_i == USC_OFS_BAUD_HI) begin
			baud_ff[11:8] <= wb_dat_i[3:0];
		end else if (wr && wb_adr_i == USC_OFS_BAUD_LO) begin
			baud_ff[7:0] <= wb_dat_i[7:0];
		end
	end

	//-----------------------------------------------------------------
	// Interrupt requests
	//-----------------------------------------------------------------
	// receive done
	assign rx_done_irq_o = ctrl_b_ff.receive_done_int_enable &&
		global_int_enable_i && rx_valid_ff;
	assign tx_done_irq_o = ctrl_b_ff.transmit_done_int_enable &&
		global_int_enable_i && tx_done_ff;
	assign tx_empty_irq_o = ctrl_b_ff.tx_buffer_empty_int_enable &&
		global_int_enable_i && !tx_buf_full_ff;

	//-----------------------------------------------------------------
	// Frame format decode
	//-----------------------------------------------------------------
	logic [2:0] size_code;
	logic [3:0] nbits;
	logic [8:0] nmask;
	logic par_en, sync_mode;
	logic [3:0] ratio_m1;

	assign size_code = {ctrl_b_ff.char_size_top_bit,
		ctrl_c_ff.char_size_low_bits};
	// parity enabled when top code bit set
	assign par_en = ctrl_c_ff.parity_setting[1];
	assign sync_mode = ctrl_c_ff.sync_mode_select;
	assign ratio_m1 = (double_speed_ff && !sync_mode) ?
		USC_RATIO_DOUBLE_M1 : USC_RATIO_NORMAL_M1;
	assign nmask = 9'h1ff >> (USC_NINE_BITS - nbits);

	// reserved sizes fall back to eight bits
	always_comb begin
		if (size_code == USC_SIZE_NINE) begin
			nbits = USC_NINE_BITS;
		end else if (!size_code[2]) begin
			nbits = USC_FIVE_BITS + {2'b00, size_code[1:0]};
		end else begin
			nbits = USC_EIGHT_BITS;
		end
	end

	//-----------------------------------------------------------------
	// Baud prescaler and clock edges
	//-----------------------------------------------------------------
	logic [11:0] pre_ff;
	logic tick, xck_ff, xck_rise, xck_fall, tx_edge, rx_edge;

	assign tick = (pre_ff == 12'h000);

	// down-counter, tick every divisor plus one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_ff <= USC_RST_BAUD;
		end else if (wr && wb_adr_i == USC_OFS_BAUD_LO) begin
			pre_ff <= {baud_ff[11:8], wb_dat_i[7:0]};
		end else if (tick) begin
			pre_ff <= baud_ff;
		end else begin
			pre_ff <= pre_ff - 12'h001;
		end
	end

	// External clock is already synchronous, so one stage suffices
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xck_ff <= 1'b0;
		end else begin
			xck_ff <= sync_serial_clock_i;
		end
	end

	assign xck_rise = sync_serial_clock_i && !xck_ff;
	assign xck_fall = !sync_serial_clock_i && xck_ff;
	assign tx_edge = ctrl_c_ff.sync_clock_polarity ? xck_fall : xck_rise;
	assign rx_edge = ctrl_c_ff.sync_clock_polarity ? xck_rise : xck_fall;

	//-----------------------------------------------------------------
	// Transmitter
	//-----------------------------------------------------------------
	usc_tx_e tx_st_ff;
	logic [3:0] tx_ph_ff, tx_cnt_ff;
	logic [8:0] tx_sh_ff;
	logic tx_par_ff, txd_ff, tx_step, tx_run, tx_load, tx_fin, buf_wr;

	// busy frame keeps the transmitter alive
	assign tx_run = ctrl_b_ff.transmitter_on || (tx_st_ff != USC_TX_IDLE) ||
		(tx_hold_ff && tx_buf_full_ff);
	assign tx_step = sync_mode ? tx_edge : (tick && tx_ph_ff == ratio_m1);
	assign tx_load = tx_buf_full_ff && tx_run;
	assign tx_fin = tx_step && ((tx_st_ff == USC_TX_STOP2) ||
		(tx_st_ff == USC_TX_STOP1 && !ctrl_c_ff.stop_count_select));
	assign buf_wr = wr && wb_adr_i == USC_OFS_DATA && !tx_buf_full_ff;
	assign txd_oe_o = tx_run;
	assign txd_o = txd_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_ph_ff <= 4'h0;
		end else if (sync_mode || !tx_run) begin
			tx_ph_ff <= 4'h0;
		end else if (tick) begin
			tx_ph_ff <= (tx_ph_ff == ratio_m1) ? 4'h0 : tx_ph_ff + 4'h1;
		end
	end

	// Queued byte still drains; a byte written while off waits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_hold_ff <= 1'b0;
		end else begin
			tx_hold_ff <= ctrl_b_ff.transmitter_on || (tx_hold_ff && tx_run);
		end
	end

	// Writes while full are dropped, not queued
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buf_ff <= 9'h0;
			tx_buf_full_ff <= 1'b0;
		end else if (buf_wr) begin
			// ninth bit taken with the data
			tx_buf_ff <= {ctrl_b_ff.transmit_ninth_bit, wb_dat_i[7:0]};
			tx_buf_full_ff <= 1'b1;
		end else if (tx_step && tx_load &&
			(tx_st_ff == USC_TX_IDLE || tx_fin)) begin
			tx_buf_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st_ff <= USC_TX_IDLE;
			tx_sh_ff <= 9'h0;
			tx_cnt_ff <= 4'h0;
			tx_par_ff <= 1'b0;
			txd_ff <= 1'b1;
		end else if (tx_step) begin
			unique case (tx_st_ff)
				USC_TX_IDLE, USC_TX_STOP1, USC_TX_STOP2: begin
					if ((tx_st_ff == USC_TX_IDLE || tx_fin) && tx_load) begin
						tx_sh_ff <= tx_buf_ff & nmask;
						txd_ff <= 1'b0;
						tx_st_ff <= USC_TX_START;
					end else if (tx_st_ff == USC_TX_STOP1 && !tx_fin) begin
						tx_st_ff <= USC_TX_STOP2;
					end else begin
						tx_st_ff <= USC_TX_IDLE;
					end
				end
				USC_TX_START: begin
					txd_ff <= tx_sh_ff[0];
					tx_par_ff <= tx_sh_ff[0];
					tx_sh_ff <= tx_sh_ff >> 1;
					tx_cnt_ff <= 4'h1;
					tx_st_ff <= USC_TX_DATA;
				end
				USC_TX_DATA: begin
					if (tx_cnt_ff != nbits) begin
						txd_ff <= tx_sh_ff[0];
						tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
						tx_sh_ff <= tx_sh_ff >> 1;
						tx_cnt_ff <= tx_cnt_ff + 4'h1;
					end else if (par_en) begin
						txd_ff <= tx_par_ff ^ ctrl_c_ff.parity_setting[0];
						tx_st_ff <= USC_TX_PAR;
					end else begin
						txd_ff <= 1'b1;
						tx_st_ff <= USC_TX_STOP1;
					end
				end
				USC_TX_PAR: begin
					txd_ff <= 1'b1;
					tx_st_ff <= USC_TX_STOP1;
				end
				default: tx_st_ff <= USC_TX_IDLE;
			endcase
		end
	end

	// Set wins over a software or interrupt clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_done_ff <= 1'b0;
		end else if (tx_fin && !tx_load) begin
			tx_done_ff <= 1'b1;
		end else if (tx_done_irq_taken_i || (wr &&
			wb_adr_i == USC_OFS_CTRL_A && wb_dat_i[USC_TX_DONE_BIT])) begin
			tx_done_ff <= 1'b0;
		end
	end

	//-----------------------------------------------------------------
	// Receiver
	//-----------------------------------------------------------------
	usc_rx_e rx_st_ff;
	logic [3:0] rx_ph_ff, rx_cnt_ff;
	logic [8:0] rx_sh_ff;
	logic rx_par_ff, rx_samp, rx_on, rx_deliver, rx_type, rd_data;

	// receiver runs and claims its pin
	assign rx_on = ctrl_b_ff.receiver_on;
	assign rxd_claim_o = rx_on;
	assign rx_samp = sync_mode ? rx_edge :
		(tick && rx_ph_ff == {1'b0, ratio_m1[3:1]});
	// one stop bit checked whatever the stop select
	assign rx_deliver = rx_samp && rx_st_ff == USC_RX_STOP;
	assign rx_type = (nbits == USC_NINE_BITS) ? rx_sh_ff[8] : rxd_i;
	assign rd_data = rd && wb_adr_i == USC_OFS_DATA;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_ph_ff <= 4'h0;
		end else if (sync_mode || rx_st_ff == USC_RX_IDLE) begin
			rx_ph_ff <= 4'h0;
		end else if (tick) begin
			rx_ph_ff <= (rx_ph_ff == ratio_m1) ? 4'h0 : rx_ph_ff + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_on) begin
			rx_st_ff <= USC_RX_IDLE;
			rx_sh_ff <= 9'h0;
			rx_cnt_ff <= 4'h0;
			rx_par_ff <= 1'b0;
		end else if (rx_st_ff == USC_RX_IDLE) begin
			rx_cnt_ff <= 4'h0;
			rx_par_ff <= 1'b0;
			if (sync_mode && rx_edge && !rxd_i) begin
				rx_st_ff <= USC_RX_DATA;
			end else if (!sync_mode && tick && !rxd_i) begin
				rx_st_ff <= USC_RX_START;
			end
		end else if (rx_samp) begin
			unique case (rx_st_ff)
				USC_RX_START: begin
					// False start when line is high at mid-bit
					rx_st_ff <= rxd_i ? USC_RX_IDLE : USC_RX_DATA;
				end
				USC_RX_DATA: begin
					rx_sh_ff <= {rxd_i, rx_sh_ff[8:1]};
					rx_par_ff <= rx_par_ff ^ rxd_i;
					rx_cnt_ff <= rx_cnt_ff + 4'h1;
					if (rx_cnt_ff + 4'h1 == nbits) begin
						rx_st_ff <= par_en ? USC_RX_PAR : USC_RX_STOP;
					end
				end
				USC_RX_PAR: begin
					rx_par_ff <= rx_par_ff ^ rxd_i;
					rx_st_ff <= USC_RX_STOP;
				end
				default: rx_st_ff <= USC_RX_IDLE;
			endcase
		end
	end

	// receiver off flushes buffer and error flags
	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_on) begin
			rx_buf_ff <= 9'h0;
			rx_valid_ff <= 1'b0;
			fe_ff <= 1'b0;
			dor_ff <= 1'b0;
			upe_ff <= 1'b0;
		end else if (rx_deliver && (!mpcm_ff || rx_type)) begin
			if (rx_valid_ff && !rd_data) begin
				dor_ff <= 1'b1;
			end else begin
				rx_buf_ff <= rx_sh_ff >> (USC_NINE_BITS - nbits);
				rx_valid_ff <= 1'b1;
				fe_ff <= !rxd_i;
				dor_ff <= 1'b0;
				upe_ff <= par_en &&
					(rx_par_ff ^ ctrl_c_ff.parity_setting[0]);
			end
		end else if (rd_data) begin
			rx_valid_ff <= 1'b0;
			fe_ff <= 1'b0;
			dor_ff <= 1'b0;
			upe_ff <= 1'b0;
		end
	end
endmodule

/* verilog/usc_pkg.sv */
// Package: register map, field layouts and timing constants of the serial port
//-----------------------------------------------------------------
// Functional notes
//-----------------------------------------------------------------
// Functional notes
// - Receive-done interrupt needs its enable, global enable and receive-done flag.
// - Transmit-done interrupt needs its enable, global enable and transmit-done flag.
// - Buffer-empty interrupt needs its enable, global enable and buffer-empty flag.
// - Receiver on runs the receiver and claims the receive pin.
// - Receiver off flushes the receive buffer and its error flags.
// - Transmitter on drives the transmit pin; released once disabled.
// - Transmitter disable waits until shifter and buffer are both empty.
// - Received ninth bit is readable; software reads it before low data.
// - Stored transmit ninth bit is sent; software writes it before data.
// - Mode select: zero asynchronous, one synchronous clocked operation.
// - Parity 00 off, 10 even, 11 odd, 01 reserved; transmitter appends it.
// - Receiver checks parity against setting and flags mismatches.
// - Stop select zero sends one stop bit, one sends two.
// - Receiver ignores the stop-bit select setting.
// - Size codes 000-011 give 5-8 bits, 111 nine, others reserved.
// - Polarity zero: transmit on rising, sample on falling; one swaps.
// - Twelve-bit divisor: high register top four, low register bottom eight.
// - Writing the low divisor register reloads the prescaler at once.
// - Double speed in asynchronous mode cuts ratio sixteen to eight.
// - Short characters: transmitter ignores, receiver zeroes upper bits.
package usc_pkg;
	//-----------------------------------------------------------------
	// Register byte offsets
	//-----------------------------------------------------------------
	localparam logic [7:0] USC_OFS_DATA = 8'h00;
	localparam logic [7:0] USC_OFS_CTRL_A = 8'h04;
	localparam logic [7:0] USC_OFS_CTRL_B = 8'h08;
	localparam logic [7:0] USC_OFS_CTRL_C = 8'h0c;
	localparam logic [7:0] USC_OFS_BAUD_LO = 8'h10;
	localparam logic [7:0] USC_OFS_BAUD_HI = 8'h14;
	//-----------------------------------------------------------------
	// Reset values and timing
	//-----------------------------------------------------------------
	localparam logic [7:0] USC_RST_CTRL_B = 8'h00;
	localparam logic [7:0] USC_RST_CTRL_C = 8'h06;
	localparam logic [11:0] USC_RST_BAUD = 12'h000;
	localparam logic [3:0] USC_RATIO_NORMAL_M1 = 4'hf;
	localparam logic [3:0] USC_RATIO_DOUBLE_M1 = 4'h7;
	localparam logic [3:0] USC_TX_DONE_BIT = 4'h6;
	localparam logic [3:0] USC_NINE_BITS = 4'h9;
	localparam logic [3:0] USC_EIGHT_BITS = 4'h8;
	localparam logic [3:0] USC_FIVE_BITS = 4'h5;
	localparam logic [2:0] USC_SIZE_NINE = 3'h7;
	//-----------------------------------------------------------------
	// Field layouts
	//-----------------------------------------------------------------
	typedef struct packed {
		logic receive_done_int_enable;
		logic transmit_done_int_enable;
		logic tx_buffer_empty_int_enable;
		logic receiver_on;
		logic transmitter_on;
		logic char_size_top_bit;
		logic received_ninth_bit;
		logic transmit_ninth_bit;
	} usc_ctrl_b_s;
	typedef struct packed {
		logic unused_top;
		logic sync_mode_select;
		logic [1:0] parity_setting;
		logic stop_count_select;
		logic [1:0] char_size_low_bits;
		logic sync_clock_polarity;
	} usc_ctrl_c_s;
	typedef enum logic [2:0] {
		USC_TX_IDLE, USC_TX_START, USC_TX_DATA,
		USC_TX_PAR, USC_TX_STOP1, USC_TX_STOP2
	} usc_tx_e;
	typedef enum logic [2:0] {
		USC_RX_IDLE, USC_RX_START, USC_RX_DATA, USC_RX_PAR, USC_RX_STOP
	} usc_rx_e;
endpackage

/* testbench/usc_properties.sv */
// Checker: port-level properties of the serial port
`timescale 1ns/100ps
module usc_properties
	import usc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic global_int_enable_i,
	input wire logic tx_done_irq_taken_i,
	input wire logic rx_done_irq_o,
	input wire logic tx_done_irq_o,
	input wire logic tx_empty_irq_o,
	input wire logic rxd_i,
	input wire logic rxd_claim_o,
	input wire logic txd_o,
	input wire logic txd_oe_o,
	input wire logic sync_serial_clock_i
);
	//-----------------------------------------------
	// Properties
	//-----------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_rx_irq; rx_done_irq_o |-> global_int_enable_i; endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq ungated");
	property p_tx_irq; tx_done_irq_o |-> global_int_enable_i; endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq ungated");
	property p_em_irq; tx_empty_irq_o |-> global_int_enable_i; endproperty
	a_em_irq: assert property (p_em_irq) else $error("empty irq ungated");
	// Pin claim only moves by a control write
	property p_claim; $changed(rxd_claim_o) |->
		wb_ack_o && wb_we_i && wb_adr_i == USC_OFS_CTRL_B; endproperty
	a_claim: assert property (p_claim) else $error("claim moved alone");
	property p_idle; !txd_oe_o |-> txd_o; endproperty
	a_idle: assert property (p_idle) else $error("released pin low");
	property p_start; $fell(txd_o) |-> txd_oe_o; endproperty
	a_start: assert property (p_start) else $error("start undriven");
	// Ratio is at least eight ticks of one clock
	property p_width; $fell(txd_o) |-> !txd_o [*8]; endproperty
	a_width: assert property (p_width) else $error("start too short");
	property p_drain; $fell(txd_oe_o) |-> $past(txd_o, 8); endproperty
	a_drain: assert property (p_drain) else $error("released mid frame");
	property p_top; wb_ack_o && !wb_we_i && wb_adr_i == USC_OFS_CTRL_C
		|-> wb_dat_o[31:7] == 25'h0; endproperty
	a_top: assert property (p_top) else $error("control c top set");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack held");
endmodule
bind usc_top usc_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.global_int_enable_i(global_int_enable_i),
	.tx_done_irq_taken_i(tx_done_irq_taken_i), .rx_done_irq_o(rx_done_irq_o),
	.tx_done_irq_o(tx_done_irq_o), .tx_empty_irq_o(tx_empty_irq_o),
	.rxd_i(rxd_i), .rxd_claim_o(rxd_claim_o), .txd_o(txd_o),
	.txd_oe_o(txd_oe_o), .sync_serial_clock_i(sync_serial_clock_i));

/* testbench/usc_remote.sv */
// Remote serial partner: drives the receive line, samples the transmit line
`timescale 1ns/100ps
module usc_remote (
	input wire logic clk_i,
	input wire logic line_i,
	output logic rxd_o,
	output logic xck_o
);
	int bit_clks = 32;
	int cap_len = 10;
	logic [15:0] cap_bits = 16'h0000;
	logic [15:0] sync_bits = 16'h0000;
	initial rxd_o = 1'b1;
	initial xck_o = 1'b0;
	//-----------------------------------------------
	// Sender and sampler
	//-----------------------------------------------
	// one stop only, whatever the far setting
	task automatic send(input logic [15:0] bits, input int n);
		rxd_o <= 1'b0;
		repeat (bit_clks) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			repeat (bit_clks) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask
	// clock idles low; line read after both edges of a bit
	task automatic sync_frame(input logic [15:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			xck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			xck_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			sync_bits[i] = line_i;
		end
		rxd_o <= 1'b1;
	endtask
	// Mid-bit sampling tolerates tick phase slack
	initial forever begin
		@(posedge clk_i);
		if (line_i === 1'b0) begin
			cap_bits = 16'h0000;
			repeat (bit_clks / 2) @(posedge clk_i);
			for (int i = 0; i < cap_len; i++) begin
				repeat (bit_clks) @(posedge clk_i);
				cap_bits[i] = line_i;
			end
		end
	end
endmodule

/* testbench/testbench.sv */
// Testbench: registers, interrupts and frames of the serial port
`timescale 1ns/100ps
module testbench;
	import usc_pkg::*;
	typedef struct {logic [7:0] a; logic w; logic [7:0] d;
		logic [7:0] e;} usc_reg_s;
	typedef struct {logic [7:0] c; logic [8:0] d; int n;} usc_frm_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic gie = 1'b0;
	logic taken = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, rx_irq, tx_irq, em_irq, rxd, claim, txd, txd_oe, line, sync_serial_clock;
	int failures = 0;
	int n_tests = 0;
	// baud high written with upper bits zero
	usc_reg_s regs [9] = '{'{USC_OFS_CTRL_B, 0, 8'h00, 8'h00},
		'{USC_OFS_CTRL_C, 0, 8'h00, 8'h06}, '{USC_OFS_BAUD_LO, 0, 8'h00, 8'h00},
		'{USC_OFS_CTRL_C, 1, 8'hff, 8'h7f}, '{USC_OFS_BAUD_HI, 1, 8'h0f, 8'h0f},
		'{USC_OFS_BAUD_LO, 1, 8'h5a, 8'h5a}, '{8'h18, 1, 8'hff, 8'h00},
		'{USC_OFS_BAUD_HI, 1, 8'h00, 8'h00}, '{USC_OFS_BAUD_LO, 1, 8'h01, 8'h01}};
	usc_frm_s frms [4] = '{'{8'h06, 9'h0a5, 8}, '{8'h20, 9'h0ff, 5},
		'{8'h3c, 9'h04d, 7}, '{8'h0e, 9'h13c, 9}};
	usc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .global_int_enable_i(gie),
		.tx_done_irq_taken_i(taken), .rx_done_irq_o(rx_irq),
		.tx_done_irq_o(tx_irq), .tx_empty_irq_o(em_irq), .rxd_i(rxd),
		.rxd_claim_o(claim), .txd_o(txd), .txd_oe_o(txd_oe),
		.sync_serial_clock_i(sync_serial_clock));
	assign line = txd_oe ? txd : 1'b1;
	usc_remote u_remote (.clk_i(clk_i), .line_i(line), .rxd_o(rxd),
		.xck_o(sync_serial_clock));
	always #12.5 clk_i = ~clk_i;
	//-----------------------------------------------
	// Tasks
	//-----------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic die(input string m);
		cmp(16'h1, 16'h0, m);
		end_of_test();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Hold the request until ack is sampled
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] r);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		adr <= a;
		we <= w;
		wdat <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		if (k >= 20)
			die("bus timeout");
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		bus(a, 1'b0, 8'h00, r);
	endtask
	task automatic wait_bit(input logic [7:0] a, input int b);
		logic [7:0] r;
		int k;
		k = 0;
		do begin
			rd(a, r);
			k++;
		end while (r[b] !== 1'b1 && k < 200);
		if (r[b] !== 1'b1)
			die("flag timeout");
	endtask
	function automatic logic [15:0] frame(input logic [8:0] d, input int n,
		input logic [1:0] par);
		logic [15:0] f;
		logic p;
		f = 16'hffff;
		p = par[0];
		for (int i = 0; i < n; i++) begin
			f[i] = d[i];
			p = p ^ d[i];
		end
		if (par[1])
			f[n] = p;
		return f;
	endfunction
	task automatic tx_check(input logic [7:0] a, input logic [7:0] c,
		input logic [8:0] d, input int n, input logic off);
		logic [15:0] m;
		m = (16'h1 << (n + c[5] + 1 + c[3])) - 16'h1;
		u_remote.cap_len = n + c[5] + 1 + c[3];
		wr(USC_OFS_CTRL_A, a);
		wr(USC_OFS_DATA, d[7:0]);
		if (off)
			wr(USC_OFS_CTRL_B, 8'h00);
		wait_bit(USC_OFS_CTRL_A, 6);
		cmp(u_remote.cap_bits & m, frame(d, n, c[5:4]) & m, "tx frame");
	endtask
	//-----------------------------------------------
	// Sequence
	//-----------------------------------------------
	initial begin
		logic [7:0] r;
		usc_frm_s f;
		logic top;
		logic [7:0] sd;
		logic [15:0] sf;
		tick(10);
		rst_i <= 1'b0;
		foreach (regs[i]) begin
			if (regs[i].w)
				wr(regs[i].a, regs[i].d);
			rd(regs[i].a, r);
			cmp(16'(r), 16'(regs[i].e), "reg row");
		end
		$display("register rows done");
		foreach (frms[i]) begin
			f = frms[i];
			top = (f.n == 9);
			wr(USC_OFS_CTRL_C, f.c);
			wr(USC_OFS_CTRL_B, {5'b00011, top, 1'b0, f.d[8]});
			tx_check(8'h40, f.c, f.d, f.n, 1'b0);
			u_remote.send(frame(f.d, f.n, f.c[5:4]), f.n + f.c[5] + 1);
			wait_bit(USC_OFS_CTRL_A, 7);
			rd(USC_OFS_CTRL_B, r);
			if (top)
				cmp(16'(r[1]), 16'(f.d[8]), "ninth bit");
			rd(USC_OFS_DATA, r);
			cmp(16'(r), 16'(f.d[7:0] & ~(8'hff << f.n)), "rx data");
			$display("frame row %0d done", i);
		end
		gie <= 1'b1;
		wr(USC_OFS_CTRL_B, 8'hf8);
		cmp(16'({rx_irq, tx_irq, em_irq}), 16'h3, "irq on");
		gie <= 1'b0;
		tick(2);
		cmp(16'({rx_irq, tx_irq, em_irq}), 16'h0, "irq global");
		gie <= 1'b1;
		taken <= 1'b1;
		tick(1);
		taken <= 1'b0;
		tick(2);
		cmp(16'({rx_irq, tx_irq, em_irq}), 16'h1, "irq taken");
		u_remote.send(frame(9'h081, 8, 2'b00), 9);
		wait_bit(USC_OFS_CTRL_A, 7);
		cmp(16'({rx_irq, tx_irq, em_irq}), 16'h5, "irq rx");
		wr(USC_OFS_CTRL_B, 8'h18);
		cmp(16'({rx_irq, tx_irq, em_irq}), 16'h0, "irq masked");
		$display("interrupt test done");
		rd(USC_OFS_DATA, r);
		wr(USC_OFS_CTRL_C, 8'h26);
		u_remote.send(frame(9'h0f0, 8, 2'b11), 10);
		wait_bit(USC_OFS_CTRL_A, 7);
		rd(USC_OFS_CTRL_A, r);
		cmp(16'(r & 8'h9c), 16'h84, "parity flag");
		wr(USC_OFS_CTRL_B, 8'h08);
		rd(USC_OFS_CTRL_A, r);
		cmp(16'({r & 8'h9c, claim}), 16'h0, "flush");
		$display("flush test done");
		tx_check(8'h40, 8'h26, 9'h033, 8, 1'b1);
		cmp(16'(txd_oe), 16'h0, "pin released");
		wr(USC_OFS_CTRL_B, 8'h08);
		u_remote.bit_clks = 16;
		for (int j = 0; j < 2; j++) begin
			wr(USC_OFS_BAUD_LO, 8'(1 - j));
			tx_check(8'h40 | 8'(2 - 2 * j), 8'h26, 9'h05a, 8, 1'b0);
		end
		$display("rate test done");
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		rd(USC_OFS_CTRL_C, r);
		cmp(16'({r, txd_oe, claim, txd}), 16'h0031, "reset state");
		rd(USC_OFS_CTRL_B, r);
		cmp(16'(r), 16'h0000, "reset ctrl b");
		$display("reset test done");
		for (int j = 0; j < 2; j++) begin
			sd = 8'hc5 ^ {8{j[0]}};
			sf = frame({1'b0, sd}, 8, 2'b00) << 1;
			wr(USC_OFS_CTRL_C, 8'h46 | 8'(j));
			wr(USC_OFS_CTRL_B, 8'h18);
			wr(USC_OFS_DATA, sd);
			u_remote.sync_frame(sf, 11);
			cmp(u_remote.sync_bits & 16'h07ff, sf & 16'h07ff, "sync tx");
			wait_bit(USC_OFS_CTRL_A, 7);
			rd(USC_OFS_DATA, r);
			cmp(16'(r), 16'(sd), "sync rx");
		end
		$display("sync test done");
		end_of_test();
	end
endmodule
